// ---- verilog/afw_pkg.sv ----
/*
  Shared constants, register map and helpers for the auto function window control.
  Assumes a byte-addressed Avalon-MM register bus with one 32-bit word per register.
*/
package afw_pkg;

  // ==========================================
  // Widths
  localparam int CW = 11;
  localparam int PW = 12;
  localparam int GW = 8;
  localparam int AW = 8;
  localparam int DW = 32;

  // ==========================================
  // Register byte offsets
  localparam logic [AW-1:0] ADR_CTRL   = 8'h00;
  localparam logic [AW-1:0] ADR_SEL    = 8'h04;
  localparam logic [AW-1:0] ADR_WIN_X  = 8'h08;
  localparam logic [AW-1:0] ADR_WIN_Y  = 8'h0c;
  localparam logic [AW-1:0] ADR_WIN_W  = 8'h10;
  localparam logic [AW-1:0] ADR_WIN_H  = 8'h14;
  localparam logic [AW-1:0] ADR_IMG_X  = 8'h18;
  localparam logic [AW-1:0] ADR_IMG_Y  = 8'h1c;
  localparam logic [AW-1:0] ADR_IMG_W  = 8'h20;
  localparam logic [AW-1:0] ADR_IMG_H  = 8'h24;
  localparam logic [AW-1:0] ADR_LOWER  = 8'h28;
  localparam logic [AW-1:0] ADR_UPPER  = 8'h2c;
  localparam logic [AW-1:0] ADR_TARGET = 8'h30;
  localparam logic [AW-1:0] ADR_PARAM  = 8'h34;
  localparam logic [AW-1:0] ADR_STATUS = 8'h38;
  localparam logic [AW-1:0] ADR_BIN    = 8'h3c;

  // ==========================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int ST_AVG_LSB    = 0;
  localparam int ST_MODE_LSB   = 8;
  localparam int ST_OVL_BIT    = 10;
  localparam int ST_FAIL_BIT   = 11;

  // ==========================================
  // Modes and timing
  typedef enum logic [1:0] {AFW_OFF, AFW_ONCE, AFW_CONT} afw_mode_e;
  localparam logic [1:0]    MODE_CODE_ONCE = 2'h1;
  localparam logic [1:0]    MODE_CODE_CONT = 2'h2;
  localparam logic [4:0]    ONCE_MAX_IMG   = 5'h1e;
  localparam logic [GW-1:0] TOL_RST        = 8'h02;
  localparam logic [PW-1:0] STEP           = 12'h001;
  localparam logic [PW-1:0] LOWER_RST      = 12'h000;
  localparam logic [PW-1:0] UPPER_RST      = 12'hfff;
  localparam logic [PW-1:0] PARAM_RST      = 12'h100;
  localparam logic [GW-1:0] TARGET_RST     = 8'h80;
  localparam logic [CW-1:0] ZERO_C         = 11'h000;

  // Pixel position test against a start and a size
  function automatic logic in_rng(input logic [CW-1:0] p, input logic [CW-1:0] s,
                                  input logic [CW-1:0] n);
    logic [CW:0] e;
    e = {1'b0, s} + {1'b0, n};
    return ({1'b0, p} >= {1'b0, s}) && ({1'b0, p} < e);
  endfunction

  // Start clamped inside the array
  function automatic logic [CW-1:0] clamp_start(input logic [CW-1:0] s, input logic [CW-1:0] lim);
    return (s >= lim) ? lim - 11'h001 : s;
  endfunction

  // Size clamped so that start plus size stays inside the array
  function automatic logic [CW-1:0] clamp_size(input logic [CW-1:0] s, input logic [CW-1:0] n,
                                               input logic [CW-1:0] lim);
    logic [CW:0] e;
    e = {1'b0, s} + {1'b0, n};
    if (n == ZERO_C) return 11'h001;
    return (e > {1'b0, lim}) ? lim - s : n;
  endfunction

endpackage

// ---- verilog/afw_stat_if.sv ----
/*
  Carrier between the control block and the statistics accumulator.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/10ps
interface afw_stat_if;
  import afw_pkg::*;
  logic [CW-1:0] win_x;
  logic [CW-1:0] win_y;
  logic [CW-1:0] win_w;
  logic [CW-1:0] win_h;
  logic [CW-1:0] img_x;
  logic [CW-1:0] img_y;
  logic [CW-1:0] img_w;
  logic [CW-1:0] img_h;
  logic          done;
  logic          overlap;
  logic [GW-1:0] avg;

  modport ctl (output win_x, win_y, win_w, win_h, img_x, img_y, img_w, img_h,
               input done, overlap, avg);
  modport acc (input win_x, win_y, win_w, win_h, img_x, img_y, img_w, img_h,
               output done, overlap, avg);
endinterface

// ---- verilog/afw_stat.sv ----
/*
  Per-image gray statistics over the overlap of statistics window and output image window.
  Assumes pixel coordinates arrive in the sensor's (binned when binning is on) grid
  and that frame_end follows the last pixel of an image.
*/
`timescale 1ns/10ps
module afw_stat (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Pixel stream
  input  wire logic              pix_valid,
  input  wire logic [afw_pkg::CW-1:0] pix_col,
  input  wire logic [afw_pkg::CW-1:0] pix_row,
  input  wire logic [afw_pkg::GW-1:0] pix_gray,
  input  wire logic              frame_end,
  // Statistics carrier
  afw_stat_if.acc                st
);
  import afw_pkg::*;

  localparam int SW = GW + 2 * CW;
  localparam int NW = 2 * CW;

  logic [SW-1:0] sum_reg;
  logic [NW-1:0] cnt_reg;
  logic          done_reg;
  logic          ovl_reg;
  logic [GW-1:0] avg_reg;

  // ==========================================
  // Window membership
  // overlap of both windows only
  wire in_stat = in_rng(pix_col, st.win_x, st.win_w) && in_rng(pix_row, st.win_y, st.win_h);
  wire in_img  = in_rng(pix_col, st.img_x, st.img_w) && in_rng(pix_row, st.img_y, st.img_h);
  wire take    = pix_valid && in_stat && in_img;
  wire cnt_nz  = (cnt_reg != '0);
  wire [SW-1:0] quot = cnt_nz ? sum_reg / SW'(cnt_reg) : '0;

  // ==========================================
  // Accumulate and close the image
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sum_reg  <= '0;
      cnt_reg  <= '0;
      done_reg <= 1'b0;
      ovl_reg  <= 1'b0;
      avg_reg  <= '0;
    end else begin
      done_reg <= frame_end;
      if (frame_end) begin
        sum_reg <= '0;
        cnt_reg <= '0;
        ovl_reg <= cnt_nz;
        avg_reg <= quot[GW-1:0];
      end else if (take) begin
        sum_reg <= sum_reg + SW'(pix_gray);
        cnt_reg <= cnt_reg + NW'(1);
      end
    end
  end

  assign st.done    = done_reg;
  assign st.overlap = ovl_reg;
  assign st.avg     = avg_reg;

  // pixels outside the overlap are not counted
  only_overlap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pix_valid && !(in_stat && in_img) && !frame_end) |=> $stable(cnt_reg))
    else $error("Pixel outside window overlap was counted");

endmodule

// ---- verilog/afw_top.sv ----
/*
  Auto function control: off / once / continuous sequencing of one brightness parameter,
  statistics windows and output image window, reached over Avalon-MM with waitrequest.
  Assumes synchronous pixel stream with a frame_end pulse per image on clk_sys.
*/
// Operation
// - Once mode adjusts, then self-switches off
// - Once mode gives up after 30 images
// - Once and continuous modes both supported
// - Continuous keeps adjusting until mode changes
// - Rerun, continuous or manual write changes parameter
// - Settings accepted while images stream
// - New mode may lag a few images
// - Window origin is column 0, row 0
// - Window is start, width, line, height
// - Only overlap pixels feed the adjustment
// - No overlap means no automatic control
// - No overlap lets manual value rule
// - Average gray steered to target within limits
// - Reset window covers full sensor
// - Window settings in one-pixel steps
// - Binning makes settings count binned units
`timescale 1ns/10ps
module afw_top #(
  parameter logic [afw_pkg::CW-1:0] SENSOR_W = 11'd659,
  parameter logic [afw_pkg::CW-1:0] SENSOR_H = 11'd494,
  parameter int                     NUM_WIN  = 2
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // Avalon-MM slave
  input  wire logic [afw_pkg::AW-1:0]   avm_address,
  input  wire logic                     avm_read,
  input  wire logic                     avm_write,
  input  wire logic [afw_pkg::DW-1:0]   avm_writedata,
  output logic      [afw_pkg::DW-1:0]   avm_readdata,
  output logic                          avm_waitrequest,
  // Pixel stream
  input  wire logic                     pix_valid,
  input  wire logic [afw_pkg::CW-1:0]   pix_col,
  input  wire logic [afw_pkg::CW-1:0]   pix_row,
  input  wire logic [afw_pkg::GW-1:0]   pix_gray,
  input  wire logic                     frame_end,
  // Applied parameter
  output logic      [afw_pkg::PW-1:0]   param_out,
  output afw_pkg::afw_mode_e            mode_out
);
  import afw_pkg::*;

  localparam int SELW = (NUM_WIN > 1) ? $clog2(NUM_WIN) : 1;

  // ==========================================
  // State
  afw_mode_e      mode_reg;
  logic [4:0]     imgs_reg;
  logic           fail_reg;
  logic [SELW-1:0] sel_reg;
  logic           bin_reg;
  logic [CW-1:0]  win_x_reg [NUM_WIN];
  logic [CW-1:0]  win_y_reg [NUM_WIN];
  logic [CW-1:0]  win_w_reg [NUM_WIN];
  logic [CW-1:0]  win_h_reg [NUM_WIN];
  logic [CW-1:0]  img_x_reg;
  logic [CW-1:0]  img_y_reg;
  logic [CW-1:0]  img_w_reg;
  logic [CW-1:0]  img_h_reg;
  logic [PW-1:0]  lower_reg;
  logic [PW-1:0]  upper_reg;
  logic [GW-1:0]  target_reg;
  logic [PW-1:0]  param_reg;
  logic [PW-1:0]  manual_reg;
  logic [DW-1:0]  rdata_reg;
  logic           wait_reg;

  afw_stat_if st ();

  // ==========================================
  // Bus decode
  // Waitrequest drops one cycle after the request; the write lands on the following edge, while it is low
  wire wr_en     = avm_write && !wait_reg;
  wire wr_ctrl   = wr_en && (avm_address == ADR_CTRL);
  wire wr_sel    = wr_en && (avm_address == ADR_SEL);
  wire wr_wx     = wr_en && (avm_address == ADR_WIN_X);
  wire wr_wy     = wr_en && (avm_address == ADR_WIN_Y);
  wire wr_ww     = wr_en && (avm_address == ADR_WIN_W);
  wire wr_wh     = wr_en && (avm_address == ADR_WIN_H);
  wire wr_ix     = wr_en && (avm_address == ADR_IMG_X);
  wire wr_iy     = wr_en && (avm_address == ADR_IMG_Y);
  wire wr_iw     = wr_en && (avm_address == ADR_IMG_W);
  wire wr_ih     = wr_en && (avm_address == ADR_IMG_H);
  wire wr_lo     = wr_en && (avm_address == ADR_LOWER);
  wire wr_hi     = wr_en && (avm_address == ADR_UPPER);
  wire wr_tgt    = wr_en && (avm_address == ADR_TARGET);
  wire wr_par    = wr_en && (avm_address == ADR_PARAM);
  wire wr_bin    = wr_en && (avm_address == ADR_BIN);
  wire [CW-1:0] wd_c = avm_writedata[CW-1:0];
  wire [1:0]    wd_m = avm_writedata[CTRL_MODE_LSB +: 2];

  // binned grid halves the array limits
  wire [CW-1:0] lim_w = bin_reg ? (SENSOR_W >> 1) : SENSOR_W;
  wire [CW-1:0] lim_h = bin_reg ? (SENSOR_H >> 1) : SENSOR_H;
  wire [CW-1:0] cur_x = win_x_reg[sel_reg];
  wire [CW-1:0] cur_y = win_y_reg[sel_reg];
  wire [CW-1:0] cur_w = win_w_reg[sel_reg];
  wire [CW-1:0] cur_h = win_h_reg[sel_reg];
  wire [CW-1:0] new_x = clamp_start(wd_c, lim_w);
  wire [CW-1:0] new_y = clamp_start(wd_c, lim_h);
  wire [CW-1:0] bin_w = avm_writedata[0] ? (SENSOR_W >> 1) : SENSOR_W;
  wire [CW-1:0] bin_h = avm_writedata[0] ? (SENSOR_H >> 1) : SENSOR_H;

  // Unknown mode codes fall back to off
  wire afw_mode_e wd_mode = (wd_m == MODE_CODE_ONCE) ? AFW_ONCE :
                            (wd_m == MODE_CODE_CONT) ? AFW_CONT : AFW_OFF;

  wire [DW-1:0] status_w = DW'({fail_reg, st.overlap, mode_reg, st.avg});
  wire [DW-1:0] rd_mux =
    (avm_address == ADR_CTRL)   ? DW'(mode_reg) :
    (avm_address == ADR_SEL)    ? DW'(sel_reg) :
    (avm_address == ADR_WIN_X)  ? DW'(cur_x) :
    (avm_address == ADR_WIN_Y)  ? DW'(cur_y) :
    (avm_address == ADR_WIN_W)  ? DW'(cur_w) :
    (avm_address == ADR_WIN_H)  ? DW'(cur_h) :
    (avm_address == ADR_IMG_X)  ? DW'(img_x_reg) :
    (avm_address == ADR_IMG_Y)  ? DW'(img_y_reg) :
    (avm_address == ADR_IMG_W)  ? DW'(img_w_reg) :
    (avm_address == ADR_IMG_H)  ? DW'(img_h_reg) :
    (avm_address == ADR_LOWER)  ? DW'(lower_reg) :
    (avm_address == ADR_UPPER)  ? DW'(upper_reg) :
    (avm_address == ADR_TARGET) ? DW'(target_reg) :
    (avm_address == ADR_PARAM)  ? DW'(param_reg) :
    (avm_address == ADR_STATUS) ? status_w :
    (avm_address == ADR_BIN)    ? DW'(bin_reg) : '0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg  <= !((avm_read || avm_write) && wait_reg);
      if (avm_read && wait_reg) rdata_reg <= rd_mux;
    end
  end

  // ==========================================
  // Windows
  // any start or size in one-pixel steps, clamped to the array
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= '0;
      bin_reg <= 1'b0;
      for (int i = 0; i < NUM_WIN; i++) begin
        // full sensor after reset, origin at 0,0
        win_x_reg[i] <= ZERO_C;
        win_y_reg[i] <= ZERO_C;
        win_w_reg[i] <= SENSOR_W;
        win_h_reg[i] <= SENSOR_H;
      end
    end else begin
      if (wr_sel) sel_reg <= avm_writedata[SELW-1:0];
      if (wr_bin) begin
        // a grid change resets every statistics window to the new full array
        bin_reg <= avm_writedata[0];
        for (int i = 0; i < NUM_WIN; i++) begin
          win_x_reg[i] <= ZERO_C;
          win_y_reg[i] <= ZERO_C;
          win_w_reg[i] <= bin_w;
          win_h_reg[i] <= bin_h;
        end
      end
      // start writes also shrink the size when needed
      if (wr_wx) begin
        win_x_reg[sel_reg] <= new_x;
        win_w_reg[sel_reg] <= clamp_size(new_x, cur_w, lim_w);
      end
      if (wr_wy) begin
        win_y_reg[sel_reg] <= new_y;
        win_h_reg[sel_reg] <= clamp_size(new_y, cur_h, lim_h);
      end
      if (wr_ww) win_w_reg[sel_reg] <= clamp_size(cur_x, wd_c, lim_w);
      if (wr_wh) win_h_reg[sel_reg] <= clamp_size(cur_y, wd_c, lim_h);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      img_x_reg  <= ZERO_C;
      img_y_reg  <= ZERO_C;
      img_w_reg  <= SENSOR_W;
      img_h_reg  <= SENSOR_H;
      lower_reg  <= LOWER_RST;
      upper_reg  <= UPPER_RST;
      target_reg <= TARGET_RST;
    end else begin
      // all settings may change while images stream
      if (wr_ix)  img_x_reg  <= wd_c;
      if (wr_iy)  img_y_reg  <= wd_c;
      if (wr_iw)  img_w_reg  <= wd_c;
      if (wr_ih)  img_h_reg  <= wd_c;
      if (wr_lo)  lower_reg  <= avm_writedata[PW-1:0];
      if (wr_hi)  upper_reg  <= avm_writedata[PW-1:0];
      if (wr_tgt) target_reg <= avm_writedata[GW-1:0];
    end
  end

  // Window 0 feeds the brightness function
  assign st.win_x = win_x_reg[0];
  assign st.win_y = win_y_reg[0];
  assign st.win_w = win_w_reg[0];
  assign st.win_h = win_h_reg[0];
  assign st.img_x = img_x_reg;
  assign st.img_y = img_y_reg;
  assign st.img_w = img_w_reg;
  assign st.img_h = img_h_reg;

  afw_stat u_stat (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .pix_valid (pix_valid),
    .pix_col   (pix_col),
    .pix_row   (pix_row),
    .pix_gray  (pix_gray),
    .frame_end (frame_end),
    .st        (st.acc)
  );

  // ==========================================
  // Adjustment
  // step toward the target, held within the limits
  wire          tick    = st.done && (mode_reg != AFW_OFF);
  wire          reached = (st.avg >= target_reg) ? (st.avg - target_reg <= TOL_RST)
                                                 : (target_reg - st.avg <= TOL_RST);
  wire [PW:0]   up_v    = {1'b0, param_reg} + {1'b0, STEP};
  wire [PW-1:0] dn_v    = (param_reg > STEP) ? param_reg - STEP : '0;
  wire [PW-1:0] raw_v   = (st.avg < target_reg) ? (up_v[PW] ? UPPER_RST : up_v[PW-1:0]) : dn_v;
  wire [PW-1:0] lim_v   = (raw_v > upper_reg) ? upper_reg : (raw_v < lower_reg) ? lower_reg : raw_v;
  wire          good    = st.overlap && reached;
  wire [4:0]    imgs_n  = imgs_reg + 5'h01;
  // thirtieth unsuccessful image ends a once run
  wire          give_up = (mode_reg == AFW_ONCE) && !good && (imgs_n >= ONCE_MAX_IMG);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_reg   <= AFW_OFF;
      imgs_reg   <= '0;
      fail_reg   <= 1'b0;
      param_reg  <= PARAM_RST;
      manual_reg <= PARAM_RST;
    end else begin
      // a manual write always takes over the parameter
      if (wr_par) begin
        param_reg  <= avm_writedata[PW-1:0];
        manual_reg <= avm_writedata[PW-1:0];
      end else if (tick) begin
        // no overlap hands brightness back to the manual value
        if (!st.overlap) param_reg <= manual_reg;
        else if (!reached) param_reg <= lim_v;
      end
      // a new mode starts on the next closed image
      if (wr_ctrl) begin
        mode_reg <= wd_mode;
        imgs_reg <= '0;
      end else if (tick && (mode_reg == AFW_ONCE)) begin
        // target reached switches the function off
        if (good || give_up) mode_reg <= AFW_OFF;
        imgs_reg <= imgs_n;
      end
      // continuous stays on until software changes the mode
      // Give-up flag: a set in the same cycle wins over the clear by a mode write
      fail_reg <= (tick && give_up) || (fail_reg && !wr_ctrl);
    end
  end

  assign avm_readdata    = rdata_reg;
  assign avm_waitrequest = wait_reg;
  assign param_out       = param_reg;
  assign mode_out        = mode_reg;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  bus_answer_a: assert property ((avm_read || avm_write) && wait_reg |=> !wait_reg)
    else $error("Bus request not answered in one cycle");
  once_done_a: assert property (tick && mode_reg == AFW_ONCE && good && !wr_ctrl |=> mode_reg == AFW_OFF)
    else $error("Once run did not switch off at target");
  once_limit_a: assert property (mode_reg == AFW_ONCE |-> imgs_reg < ONCE_MAX_IMG)
    else $error("Once run exceeded image limit");
  cont_hold_a: assert property (mode_reg == AFW_CONT && !wr_ctrl |=> mode_reg == AFW_CONT)
    else $error("Continuous mode left without a mode write");
  manual_wr_a: assert property (wr_par |=> param_reg == $past(avm_writedata[PW-1:0]))
    else $error("Manual parameter write lost");
  no_ovl_a: assert property (tick && !st.overlap && !wr_par |=> param_reg == manual_reg)
    else $error("No overlap did not restore manual value");
  in_limits_a: assert property (tick && st.overlap && !reached && !wr_par && lower_reg <= upper_reg
    |=> param_reg >= lower_reg && param_reg <= upper_reg)
    else $error("Adjusted parameter outside limits");
  win_clamp_a: assert property ({1'b0, win_x_reg[0]} + {1'b0, win_w_reg[0]} <= {1'b0, lim_w}
    && {1'b0, win_y_reg[0]} + {1'b0, win_h_reg[0]} <= {1'b0, lim_h})
    else $error("Statistics window leaves the array");

  once_ok_c:   cover property (mode_reg == AFW_ONCE ##1 mode_reg == AFW_OFF && !fail_reg);
  once_fail_c: cover property (tick && give_up);
  cont_adj_c:  cover property (tick && mode_reg == AFW_CONT && st.overlap && !reached);
  no_ovl_c:    cover property (tick && !st.overlap);

endmodule

// ---- dv/auto_function_window_control_tb.sv ----
/*
  Self-checking bench for the auto function window control top.
  Assumes afw_pkg and afw_stat_if are compiled first; drives the bus and pixels itself.
*/
`timescale 1ns/10ps
module auto_function_window_control_tb;
  import afw_pkg::*;
  // ==========================================
  // Signals
  logic          clk_sys = 1'b0;
  logic          nrst = 1'b0;
  logic [AW-1:0] avm_address = 8'h00;
  logic          avm_read = 1'b0;
  logic          avm_write = 1'b0;
  logic [DW-1:0] avm_writedata = 32'h0;
  logic [DW-1:0] avm_readdata;
  logic          avm_waitrequest;
  logic          pix_valid = 1'b0;
  logic [CW-1:0] pix_col = 11'h000;
  logic [CW-1:0] pix_row = 11'h000;
  logic [GW-1:0] pix_gray = 8'h00;
  logic          frame_end = 1'b0;
  logic [PW-1:0] param_out;
  afw_mode_e     mode_out;
  int            n_fail = 0;
  int            tests_run = 0;
  logic [DW-1:0] rd;

  afw_top i_afw_top (.clk_sys(clk_sys), .nrst(nrst), .avm_address(avm_address), .avm_read(avm_read),
    .avm_write(avm_write), .avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .pix_valid(pix_valid), .pix_col(pix_col), .pix_row(pix_row),
    .pix_gray(pix_gray), .frame_end(frame_end), .param_out(param_out), .mode_out(mode_out));

  always #5 clk_sys = ~clk_sys;

  // ==========================================
  // Helpers
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits are bounded; waitrequest is sampled before the edge's own updates land
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= wr;
    avm_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 50);
    rd = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic rchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // Four columns by two rows; columns 0-1 carry ga, columns 2-3 carry gb
  task automatic frame(input logic [GW-1:0] ga, input logic [GW-1:0] gb);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge clk_sys);
        pix_valid <= 1'b1;
        pix_col <= 11'(c);
        pix_row <= 11'(r);
        pix_gray <= (c < 2) ? ga : gb;
      end
    end
    @(posedge clk_sys);
    pix_valid <= 1'b0;
    frame_end <= 1'b1;
    @(posedge clk_sys);
    frame_end <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // Let the edge that lands a bus write pass before the outputs are judged
  task automatic chk_out(input logic [PW-1:0] p, input logic [1:0] m);
    @(posedge clk_sys);
    chk("param_out", {20'h0, p}, {20'h0, param_out});
    chk("mode_out", {30'h0, m}, {30'h0, mode_out});
  endtask

  // ==========================================
  // Scenarios
  task automatic sc_reset();
    chk_out(PARAM_RST, 2'h0);
    chk("waitrequest", 32'h1, {31'h0, avm_waitrequest});
    rchk("win_x", ADR_WIN_X, 32'h0);
    rchk("win_w", ADR_WIN_W, 32'd659);
    rchk("win_h", ADR_WIN_H, 32'd494);
    rchk("unmapped", 8'h40, 32'h0);
  endtask

  // Dark images never reach target: 30 steps, then off with give-up flag
  task automatic sc_once_fail();
    bus(1'b1, ADR_CTRL, 32'h1);
    for (int i = 0; i < 29; i++) frame(8'h00, 8'h00);
    chk_out(12'h11d, 2'h1);
    frame(8'h00, 8'h00);
    chk_out(12'h11e, 2'h0);
    rchk("fail", ADR_STATUS, 32'h0000_0c00);
  endtask

  task automatic sc_once_ok();
    bus(1'b1, ADR_CTRL, 32'h1);
    frame(8'h80, 8'h80);
    chk_out(12'h11e, 2'h0);
    rchk("status", ADR_STATUS, 32'h0000_0480);
  endtask

  task automatic sc_cont();
    bus(1'b1, ADR_CTRL, 32'h2);
    frame(8'h00, 8'h00);
    frame(8'h00, 8'h00);
    frame(8'h00, 8'h00);
    chk_out(12'h121, 2'h2);
    bus(1'b1, ADR_CTRL, 32'h3);
    frame(8'h00, 8'h00);
    chk_out(12'h121, 2'h0);
    bus(1'b1, ADR_PARAM, 32'h50);
    chk_out(12'h050, 2'h0);
  endtask

  task automatic sc_limit();
    bus(1'b1, ADR_UPPER, 32'h52);
    bus(1'b1, ADR_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) frame(8'h00, 8'h00);
    chk_out(12'h052, 2'h2);
    bus(1'b1, ADR_CTRL, 32'h0);
  endtask

  // Image window limited to columns 0-1, so the dark columns must be ignored
  task automatic sc_overlap();
    bus(1'b1, ADR_IMG_W, 32'h2);
    bus(1'b1, ADR_CTRL, 32'h1);
    frame(8'h80, 8'h00);
    chk_out(12'h052, 2'h0);
    bus(1'b1, ADR_IMG_X, 32'd100);
    bus(1'b1, ADR_CTRL, 32'h2);
    frame(8'h00, 8'h00);
    chk_out(12'h050, 2'h2);
    rchk("no_ovl", ADR_STATUS, 32'h0000_0200);
    bus(1'b1, ADR_CTRL, 32'h0);
  endtask

  task automatic sc_window();
    bus(1'b1, ADR_SEL, 32'h1);
    bus(1'b1, ADR_WIN_X, 32'd7);
    rchk("sel1_x", ADR_WIN_X, 32'd7);
    bus(1'b1, ADR_SEL, 32'h0);
    rchk("sel0_x", ADR_WIN_X, 32'h0);
    bus(1'b1, ADR_WIN_X, 32'd700);
    rchk("clamp_x", ADR_WIN_X, 32'd658);
    rchk("shrink_w", ADR_WIN_W, 32'd1);
    bus(1'b1, ADR_WIN_Y, 32'd3);
    bus(1'b1, ADR_WIN_H, 32'd1000);
    rchk("clamp_h", ADR_WIN_H, 32'd491);
    bus(1'b1, ADR_WIN_H, 32'd0);
    rchk("zero_h", ADR_WIN_H, 32'd1);
    bus(1'b1, ADR_BIN, 32'h1);
    rchk("bin_w", ADR_WIN_W, 32'd329);
    bus(1'b1, ADR_WIN_X, 32'd400);
    rchk("bin_x", ADR_WIN_X, 32'd328);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    sc_reset();
    sc_once_fail();
    sc_once_ok();
    sc_cont();
    sc_limit();
    sc_overlap();
    sc_window();
    wrap_up();
  end
endmodule
